// [rtl/lscb_pkg.sv]
package lscb_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] LSCB_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] LSCB_ADDR_CHECKSUM = 4'h1;
  localparam logic [3:0] LSCB_ADDR_BREAK_LIMIT = 4'h2;
  localparam logic [3:0] LSCB_ADDR_DATA = 4'h3;
  localparam logic [3:0] LSCB_ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0] LSCB_ADDR_IRQ_MASK = 4'h5;
  localparam logic [3:0] LSCB_ADDR_STATE = 4'h6;
  // Control word field positions
  localparam int LSCB_B_MODE_TX = 0;
  localparam int LSCB_B_TXRDY_MASK = 1;
  localparam int LSCB_B_COMB_MASK = 6;
  localparam int LSCB_B_CLASSIC = 7;
  localparam int LSCB_B_SEND_CS = 8;
  localparam int LSCB_B_SYNC_TIMING = 9;
  localparam int LSCB_B_TEST_TX = 10;
  localparam int LSCB_B_ENABLE = 11;
  localparam int LSCB_B_BYPASS = 12;
  localparam logic [15:0] LSCB_CTRL_WMASK = 16'h1FFF;
  localparam logic [15:0] LSCB_CTRL_RESET = 16'h0000;
  // Interrupt status bit positions
  localparam int LSCB_I_COLLISION = 0;
  localparam int LSCB_I_TX_DONE = 1;
  localparam int LSCB_I_BREAK = 2;
  localparam int LSCB_I_RX_BYTE = 3;
  localparam int LSCB_I_TX_READY = 4;
  localparam int LSCB_NIRQ = 5;
  // Reset values and timing
  localparam logic [7:0] LSCB_CS_RESET = 8'hFF;
  localparam logic [18:0] LSCB_BREAK_LIMIT_RESET = 19'h0_157C;
  localparam int LSCB_CLK_MHZ = 25;
  localparam int LSCB_SYNC_LOW_CLKS = 750;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } lscb_bus_t;
endpackage

// [rtl/lscb_uart.sv]
`timescale 1ns/1ps
`default_nettype none
// Byte transmitter: start, eight data bits LSB first, stop
module lscb_uart #(
  parameter int BIT_CLKS = 1250
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic start,
  input wire logic [7:0] data,
  output logic busy,
  output logic done,
  output logic txd
);
  initial begin
    if (BIT_CLKS < 2) $error("BIT_CLKS too small");
  end
  logic [15:0] cnt_reg;
  logic [3:0] bit_reg;
  logic [9:0] sh_reg;
  // Shift register paced by the bit counter
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 16'h0000;
      bit_reg <= 4'h0;
      sh_reg <= 10'h3FF;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (clear) begin
      busy <= 1'b0;
      done <= 1'b0;
      sh_reg <= 10'h3FF;
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        sh_reg <= {1'b1, data, 1'b0};
        busy <= 1'b1;
        bit_reg <= 4'h0;
        cnt_reg <= 16'h0000;
      end else if (busy) begin
        if (cnt_reg == 16'(BIT_CLKS - 1)) begin
          cnt_reg <= 16'h0000;
          sh_reg <= {1'b1, sh_reg[9:1]};
          if (bit_reg == 4'h9) begin
            busy <= 1'b0;
            done <= 1'b1;
          end else begin
            bit_reg <= bit_reg + 4'h1;
          end
        end else begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end
    end
  end
  assign txd = sh_reg[0];
endmodule
`default_nettype wire

// [rtl/lscb_core.sv]
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module lscb_core
  import lscb_pkg::*;
#(
  parameter int BIT_CLKS = 1250
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire lscb_bus_t bus,
  output logic [15:0] rdata,
  input wire logic lin_rx,
  input wire logic collision_in,
  input wire logic sw_lin_drive,
  output logic lin_tx,
  output logic lin_tx_en,
  output logic irq
);
  localparam int SYNC_CLKS = LSCB_SYNC_LOW_CLKS * LSCB_CLK_MHZ / 25;
  initial begin
    if (BIT_CLKS < 2 || BIT_CLKS > 65535) $error("BIT_CLKS out of range");
  end

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_BREAK = 5'b00010,
    ST_SYNC = 5'b00100,
    ST_PID = 5'b01000,
    ST_DATA = 5'b10000
  } lscb_state_t;

  function automatic logic [7:0] lscb_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction

  logic [15:0] ctrl_reg;
  logic [7:0] sum_reg;
  logic [18:0] brk_lim_reg;
  logic [7:0] data_reg;
  logic [LSCB_NIRQ-1:0] ist_reg;
  logic [LSCB_NIRQ-1:0] imask_reg;
  lscb_state_t state_reg;
  logic [18:0] low_cnt_reg;
  logic tx_finished_reg;
  logic rx_s1, rx_s2, rx_d;
  logic col_s1, col_s2, col_d;
  logic [15:0] rx_cnt_reg;
  logic [3:0] rx_bit_reg;
  logic [7:0] rx_sh_reg;
  logic rx_busy_reg;
  logic rx_byte_evt;
  logic cs_pending_reg;
  logic tx_start, tx_busy, tx_done, tx_txd;
  logic [7:0] tx_byte;
  logic enabled, bypass, wr_ctrl, wr_data, col_evt, break_evt, classic_flip;

  assign enabled = ctrl_reg[LSCB_B_ENABLE];
  assign bypass = ctrl_reg[LSCB_B_BYPASS];
  assign wr_ctrl = bus.wr && bus.addr == LSCB_ADDR_CONTROL;
  assign wr_data = bus.wr && bus.addr == LSCB_ADDR_DATA;
  assign classic_flip = wr_ctrl &&
    (bus.wdata[LSCB_B_CLASSIC] != ctrl_reg[LSCB_B_CLASSIC]);

  // Pin inputs cross in two flops; a third flop delays the second for edge detection
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_d <= 1'b1;
      col_s1 <= 1'b0;
      col_s2 <= 1'b0;
      col_d <= 1'b0;
    end else begin
      rx_s1 <= lin_rx;
      rx_s2 <= rx_s1;
      rx_d <= rx_s2;
      col_s1 <= collision_in;
      col_s2 <= col_s1;
      col_d <= col_s2;
    end
  end
  assign col_evt = col_s2 && !col_d && enabled && !bypass;

  // Control word; hardware clears send-checksum after it goes out
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= LSCB_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= bus.wdata & LSCB_CTRL_WMASK;
        if (bus.wdata[LSCB_B_SEND_CS]) begin
          ctrl_reg[LSCB_B_TXRDY_MASK] <= 1'b1;
        end
      end else if (cs_pending_reg && tx_done) begin
        ctrl_reg[LSCB_B_SEND_CS] <= 1'b0;
      end
      if (break_evt) begin
        ctrl_reg[LSCB_B_MODE_TX] <= 1'b0;
      end
    end
  end

  // Break limit and data buffer registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      brk_lim_reg <= LSCB_BREAK_LIMIT_RESET;
      data_reg <= 8'h00;
    end else begin
      if (bus.wr && bus.addr == LSCB_ADDR_BREAK_LIMIT) begin
        brk_lim_reg <= {3'b000, bus.wdata};
      end
      if (wr_data) begin
        data_reg <= bus.wdata[7:0];
      end else if (rx_byte_evt) begin
        data_reg <= rx_sh_reg;
      end
    end
  end

  // Frame tracker: break timing, then sync, identifier, data
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      low_cnt_reg <= 19'h0_0000;
    end else if (!enabled || bypass) begin
      state_reg <= ST_IDLE;
      low_cnt_reg <= 19'h0_0000;
    end else begin
      if (!rx_s2) begin
        if (low_cnt_reg != 19'h7_FFFF) begin
          low_cnt_reg <= low_cnt_reg + 19'h0_0001;
        end
      end else begin
        low_cnt_reg <= 19'h0_0000;
      end
      case (state_reg)
        ST_IDLE: begin
          if (!rx_s2 && rx_d) begin
            state_reg <= ST_BREAK;
          end
        end
        ST_BREAK: begin
          if (break_evt) begin
            state_reg <= ST_SYNC;
          end else if (rx_s2) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_SYNC: begin
          // A long first sync bit is a second break still being timed
          if (ctrl_reg[LSCB_B_SYNC_TIMING] && !rx_s2 &&
              low_cnt_reg >= 19'(SYNC_CLKS)) begin
            state_reg <= ST_BREAK;
          end else if (rx_byte_evt) begin
            state_reg <= ST_PID;
          end
        end
        ST_PID: begin
          if (rx_byte_evt) begin
            state_reg <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (break_evt) begin
            state_reg <= ST_SYNC;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
  // Break ends on the rising edge, length between 11 bits and limit
  assign break_evt = enabled && !bypass && rx_s2 && !rx_d &&
    low_cnt_reg >= 19'(BIT_CLKS * 11) && low_cnt_reg <= brk_lim_reg;

  // Receiver samples mid bit; the rate is fixed, not recovered
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_busy_reg <= 1'b0;
      rx_cnt_reg <= 16'h0000;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      rx_byte_evt <= 1'b0;
    end else begin
      rx_byte_evt <= 1'b0;
      if (!enabled || bypass || state_reg == ST_IDLE || state_reg == ST_BREAK) begin
        rx_busy_reg <= 1'b0;
      end else if (!rx_busy_reg) begin
        if (!rx_s2 && rx_d) begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg <= 16'(BIT_CLKS / 2);
          rx_bit_reg <= 4'h0;
        end
      end else if (rx_cnt_reg == 16'(BIT_CLKS - 1)) begin
        rx_cnt_reg <= 16'h0000;
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg != 4'h0 && rx_bit_reg != 4'h9) begin
          rx_sh_reg <= {rx_s2, rx_sh_reg[7:1]};
        end
        if (rx_bit_reg == 4'h9) begin
          rx_busy_reg <= 1'b0;
          rx_byte_evt <= 1'b1;
        end
      end else begin
        rx_cnt_reg <= rx_cnt_reg + 16'h0001;
      end
    end
  end

  // Transmit scheduler; test mode skips the header wait
  assign tx_start = !tx_busy && !cs_pending_reg && enabled && !bypass &&
    (ctrl_reg[LSCB_B_TEST_TX] || ctrl_reg[LSCB_B_MODE_TX]) &&
    (ctrl_reg[LSCB_B_SEND_CS] || wr_data);
  assign tx_byte = ctrl_reg[LSCB_B_SEND_CS] ? sum_reg : bus.wdata[7:0];
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cs_pending_reg <= 1'b0;
      tx_finished_reg <= 1'b0;
    end else if (!enabled) begin
      cs_pending_reg <= 1'b0;
      tx_finished_reg <= 1'b0;
    end else begin
      if (tx_start && ctrl_reg[LSCB_B_SEND_CS]) begin
        cs_pending_reg <= 1'b1;
      end else if (tx_done) begin
        cs_pending_reg <= 1'b0;
      end
      if (cs_pending_reg && tx_done) begin
        tx_finished_reg <= 1'b1;
      end else if (break_evt) begin
        tx_finished_reg <= 1'b0;
      end
    end
  end

  lscb_uart #(
    .BIT_CLKS(BIT_CLKS)
  ) u_tx (
    .mclk(mclk),
    .rstn(rstn),
    .clear(!enabled || bypass),
    .start(tx_start),
    .data(tx_byte),
    .busy(tx_busy),
    .done(tx_done),
    .txd(tx_txd)
  );

  // Checksum accumulator keeps the inverted sum
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sum_reg <= LSCB_CS_RESET;
    end else if (!enabled || break_evt || classic_flip) begin
      sum_reg <= LSCB_CS_RESET;
    end else if (bus.wr && bus.addr == LSCB_ADDR_CHECKSUM) begin
      sum_reg <= bus.wdata[7:0];
    end else if (rx_byte_evt && state_reg != ST_SYNC &&
                 !(state_reg == ST_PID && ctrl_reg[LSCB_B_CLASSIC])) begin
      sum_reg <= ~lscb_add(~sum_reg, rx_sh_reg);
    end else if (tx_start && !ctrl_reg[LSCB_B_SEND_CS]) begin
      sum_reg <= ~lscb_add(~sum_reg, bus.wdata[7:0]);
    end
  end

  // Sticky events; set wins over write-one-to-clear
  logic [LSCB_NIRQ-1:0] ev;
  always_comb begin
    ev = '0;
    // Mask only hides collisions once the transmit has finished
    ev[LSCB_I_COLLISION] = col_evt &&
      (!ctrl_reg[LSCB_B_COMB_MASK] || !tx_finished_reg);
    ev[LSCB_I_TX_DONE] = tx_done && cs_pending_reg && !ctrl_reg[LSCB_B_COMB_MASK];
    ev[LSCB_I_BREAK] = break_evt;
    ev[LSCB_I_RX_BYTE] = rx_byte_evt;
    ev[LSCB_I_TX_READY] = tx_done && !ctrl_reg[LSCB_B_TXRDY_MASK];
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ist_reg <= '0;
      imask_reg <= '0;
    end else begin
      if (bus.wr && bus.addr == LSCB_ADDR_IRQ_MASK) begin
        imask_reg <= bus.wdata[LSCB_NIRQ-1:0];
      end
      if (bus.wr && bus.addr == LSCB_ADDR_IRQ_STATUS) begin
        ist_reg <= (ist_reg & ~bus.wdata[LSCB_NIRQ-1:0]) | ev;
      end else begin
        ist_reg <= ist_reg | ev;
      end
    end
  end

  // Outputs and read data all registered
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 16'h0000;
      lin_tx <= 1'b1;
      lin_tx_en <= 1'b0;
      irq <= 1'b0;
    end else begin
      irq <= |(ist_reg & ~imask_reg);
      if (bypass) begin
        lin_tx <= sw_lin_drive;
        lin_tx_en <= 1'b1;
      end else begin
        lin_tx <= tx_txd;
        lin_tx_en <= tx_busy;
      end
      rdata <= 16'h0000;
      if (bus.rd) begin
        case (bus.addr)
          LSCB_ADDR_CONTROL: rdata <= ctrl_reg & LSCB_CTRL_WMASK;
          LSCB_ADDR_CHECKSUM: rdata <= {8'h00, sum_reg};
          LSCB_ADDR_BREAK_LIMIT: rdata <= brk_lim_reg[15:0];
          LSCB_ADDR_DATA: rdata <= {8'h00, data_reg};
          LSCB_ADDR_IRQ_STATUS: rdata <= 16'(ist_reg);
          LSCB_ADDR_IRQ_MASK: rdata <= 16'(imask_reg);
          LSCB_ADDR_STATE: rdata <= {10'h000, tx_finished_reg, state_reg};
          default: rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Checks
  chk_cs_clear: assert property (@(posedge mclk) disable iff (!rstn)
    cs_pending_reg && tx_done && !wr_ctrl |=> !ctrl_reg[LSCB_B_SEND_CS])
    else $error("send checksum not cleared");
  chk_txrdy_mask: assert property (@(posedge mclk) disable iff (!rstn)
    wr_ctrl && bus.wdata[LSCB_B_SEND_CS] |=> ctrl_reg[LSCB_B_TXRDY_MASK])
    else $error("transmit ready mask not set");
  chk_reserved_zero: assert property (@(posedge mclk) disable iff (!rstn)
    ctrl_reg[15:13] == 3'b000) else $error("reserved bits set");
  chk_disable_reset: assert property (@(posedge mclk) disable iff (!rstn)
    !enabled |=> state_reg == ST_IDLE && sum_reg == LSCB_CS_RESET)
    else $error("disable did not reset");
  chk_type_flip: assert property (@(posedge mclk) disable iff (!rstn)
    classic_flip |=> sum_reg == LSCB_CS_RESET) else $error("checksum not reset");
  chk_col_unmasked: assert property (@(posedge mclk) disable iff (!rstn)
    col_evt && !ctrl_reg[LSCB_B_COMB_MASK] |=> ist_reg[LSCB_I_COLLISION])
    else $error("collision lost");
  chk_col_masked: assert property (@(posedge mclk) disable iff (!rstn)
    col_evt && ctrl_reg[LSCB_B_COMB_MASK] && tx_finished_reg |-> !ev[LSCB_I_COLLISION])
    else $error("masked collision flagged");
  chk_col_early: assert property (@(posedge mclk) disable iff (!rstn)
    col_evt && !tx_finished_reg |=> ist_reg[LSCB_I_COLLISION])
    else $error("early collision lost");
  chk_bypass_pin: assert property (@(posedge mclk) disable iff (!rstn)
    bypass |=> lin_tx_en && lin_tx == $past(sw_lin_drive))
    else $error("bypass not driving");
  chk_txdone_mask: assert property (@(posedge mclk) disable iff (!rstn)
    ctrl_reg[LSCB_B_COMB_MASK] |-> !ev[LSCB_I_TX_DONE])
    else $error("masked tx done");
  cov_break: cover property (@(posedge mclk) disable iff (!rstn) break_evt);
  cov_cs_sent: cover property (@(posedge mclk) disable iff (!rstn) cs_pending_reg && tx_done);
  cov_col_masked: cover property (@(posedge mclk) disable iff (!rstn)
    col_evt && tx_finished_reg && ctrl_reg[LSCB_B_COMB_MASK]);
endmodule
`default_nettype wire

// [dv/lscb_lin_master.sv]
`timescale 1ns/1ps
`default_nettype none
// Master node on the wire: sends break, sync and bytes, and reads bytes back
module lscb_lin_master #(
  parameter int BIT_CLKS = 8
) (
  input wire logic mclk,
  input wire logic line,
  output logic drive
);
  // Recessive at rest; the pull-up carries the wire when nobody drives
  initial drive = 1'b1;

  // Hold one level for n clocks, changed right after an edge
  task automatic put(input logic lvl, input int n);
    drive <= lvl;
    repeat (n) @(posedge mclk);
  endtask

  // Break of 13 bit times, then a one-bit delimiter
  task automatic send_break();
    put(1'b0, 13 * BIT_CLKS);
    put(1'b1, BIT_CLKS);
  endtask

  // Start bit, eight bits LSB first, stop plus one idle bit
  task automatic send_byte(input logic [7:0] b);
    int k;
    put(1'b0, BIT_CLKS);
    for (k = 0; k < 8; k++) begin
      put(b[k], BIT_CLKS);
    end
    put(1'b1, 2 * BIT_CLKS);
  endtask

  // Sample mid-bit on the falling clock so no edge race decides a bit
  task automatic get_byte(output logic [7:0] b);
    int t;
    int k;
    b = 'x;
    for (t = 0; t < 4000 && line !== 1'b0; t++) begin
      @(negedge mclk);
    end
    if (line === 1'b0) begin
      repeat (BIT_CLKS / 2) @(negedge mclk);
      for (k = 0; k < 8; k++) begin
        repeat (BIT_CLKS) @(negedge mclk);
        b[k] = line;
      end
      repeat (BIT_CLKS) @(negedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// [dv/lin_slave_control_bits_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module lin_slave_control_bits_bench;
  import lscb_pkg::*;
  localparam int B = 8;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  lscb_bus_t bus = '0;
  logic collision_in = 1'b0;
  logic sw_lin_drive = 1'b1;
  logic [15:0] rdata;
  logic lin_tx, lin_tx_en, irq, m_drive;
  wire logic lin_line;
  int n_errors = 0;
  int total_checks = 0;
  integer seed = 45;
  logic [15:0] v;
  logic [7:0] d, pid, d1, d2, got;
  int q[$];
  int m, i;

  // Wired-AND wire with pull-up
  assign lin_line = m_drive & (lin_tx_en ? lin_tx : 1'b1);

  lscb_core #(.BIT_CLKS(B)) lscb_core_inst (.mclk(mclk), .rstn(rstn), .bus(bus),
    .rdata(rdata), .lin_rx(lin_line), .collision_in(collision_in),
    .sw_lin_drive(sw_lin_drive), .lin_tx(lin_tx), .lin_tx_en(lin_tx_en), .irq(irq));
  lscb_lin_master #(.BIT_CLKS(B)) lscb_lin_master_inst (.mclk(mclk), .line(lin_line),
    .drive(m_drive));

  // 25 MHz core clock
  initial forever #20 mclk = ~mclk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] w);
    @(posedge mclk);
    bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [3:0] a, input logic [15:0] msk, input logic [15:0] exp);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 check(rdata & msk, exp);
  endtask

  task automatic wait_clks(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Collision input is synchronised, so hold it several clocks
  task automatic bump();
    @(posedge mclk);
    collision_in <= 1'b1;
    wait_clks(4);
    collision_in <= 1'b0;
    wait_clks(6);
  endtask

  // Inverted sum with end-around carry
  function automatic logic [7:0] lin_sum(input int qq[$]);
    int s;
    s = 0;
    foreach (qq[k]) begin
      s += qq[k];
      if (s > 255) s -= 255;
    end
    return ~s[7:0];
  endfunction

  task automatic summarize();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Whole run needs well under 20000 clocks
  initial begin
    #(40 * 40000);
    n_errors++;
    summarize();
  end

  initial begin
    wait_clks(10);
    rstn <= 1'b1;
    rchk(LSCB_ADDR_CONTROL, 16'hFFFF, LSCB_CTRL_RESET);
    rchk(LSCB_ADDR_CHECKSUM, 16'hFFFF, 16'h00FF);
    rchk(LSCB_ADDR_BREAK_LIMIT, 16'hFFFF, 16'h157C);
    rchk(4'h7, 16'hFFFF, 16'h0000);
    wr(LSCB_ADDR_CONTROL, 16'hE000);
    rchk(LSCB_ADDR_CONTROL, 16'hFFFF, 16'h0000);
    // Short bit time needs a limit above the 13-bit break
    wr(LSCB_ADDR_BREAK_LIMIT, 16'd200);
    $display("test registers done");
    d = $random(seed);
    wr(LSCB_ADDR_CONTROL, 16'h0C80);
    wr(LSCB_ADDR_DATA, {8'h00, d});
    lscb_lin_master_inst.get_byte(got);
    check({8'h00, got}, {8'h00, d});
    wait_clks(2 * B);
    wr(LSCB_ADDR_CONTROL, 16'h0D80);
    lscb_lin_master_inst.get_byte(got);
    q = {d};
    check({8'h00, got}, {8'h00, lin_sum(q)});
    wait_clks(2 * B);
    rchk(LSCB_ADDR_CONTROL, 16'h1FFF, 16'h0C82);
    rchk(LSCB_ADDR_IRQ_STATUS, 16'h0003, 16'h0002);
    $display("test transmit done");
    wr(LSCB_ADDR_IRQ_STATUS, 16'h001F);
    wr(LSCB_ADDR_CONTROL, 16'h0C80);
    wr(LSCB_ADDR_IRQ_MASK, 16'h001E);
    bump();
    rchk(LSCB_ADDR_IRQ_STATUS, 16'h0001, 16'h0001);
    check({15'h0, irq}, 16'h0001);
    wr(LSCB_ADDR_IRQ_MASK, 16'h001F);
    wait_clks(3);
    check({15'h0, irq}, 16'h0000);
    wr(LSCB_ADDR_IRQ_MASK, 16'h001E);
    wr(LSCB_ADDR_IRQ_STATUS, 16'h0001);
    wait_clks(3);
    check({15'h0, irq}, 16'h0000);
    wr(LSCB_ADDR_CONTROL, 16'h0CC0);
    bump();
    rchk(LSCB_ADDR_IRQ_STATUS, 16'h0001, 16'h0000);
    $display("test collision done");
    // Enhanced first, then classic; a good frame leaves zero behind
    for (m = 0; m < 2; m++) begin
      wr(LSCB_ADDR_CONTROL, 16'h0840 | 16'(m << 7));
      v = $random(seed);
      pid = v[7:0];
      d1 = v[15:8];
      d2 = $random(seed);
      q = {d1, d2};
      if (m == 0) q.push_front(pid);
      lscb_lin_master_inst.send_break();
      lscb_lin_master_inst.send_byte(8'h55);
      lscb_lin_master_inst.send_byte(pid);
      lscb_lin_master_inst.send_byte(d1);
      lscb_lin_master_inst.send_byte(d2);
      lscb_lin_master_inst.send_byte(lin_sum(q));
      wait_clks(2 * B);
      rchk(LSCB_ADDR_CHECKSUM, 16'h00FF, 16'h0000);
      rchk(LSCB_ADDR_IRQ_STATUS, 16'h0004, 16'h0004);
    end
    // Break cleared the finished state, so the mask no longer hides it
    bump();
    rchk(LSCB_ADDR_IRQ_STATUS, 16'h0001, 16'h0001);
    $display("test receive done");
    wr(LSCB_ADDR_CONTROL, 16'h0000);
    rchk(LSCB_ADDR_CHECKSUM, 16'h00FF, 16'h00FF);
    wr(LSCB_ADDR_DATA, 16'h0000);
    wait_clks(30);
    check({14'h0, lin_tx_en, lin_tx}, 16'h0001);
    wr(LSCB_ADDR_CONTROL, 16'h1000);
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      sw_lin_drive <= v[0];
      wait_clks(4);
      check({14'h0, lin_tx_en, lin_tx}, {14'h0, 1'b1, v[0]});
    end
    $display("test enable and bypass done");
    summarize();
  end
endmodule
`default_nettype wire
